// ===== src/gscp_command_port.v
`include "gscp_regs.vh"

// Functional notes
// - Each command holds two data bytes; command code then data transfer.
// - Each command owns two consecutive codes; control word at 0 and 1.
// - Bus commands read control, status and data locations; only control and temperature take writes.
// - Five power modes, entered automatically on their events.
// - Host can enter some power modes directly with commands.
// - Internal temperature by default; host-written temperature overrides.
// - Answer only seven-bit address 1010101, bytes 0xAA and 0xAB.
// - Command pointer advances on each acknowledged data byte.
// - Data written to a read-only location is not acknowledged.
// - Read from a command code above 0x6B gets the read address byte NACKed.
module gscp_command_port #(
  parameter IDLE_CYC = `GSCP_IDLE_CYC
) (
  input wire ref_clk,
  input wire rst,
  input wire scl_in,
  input wire sda_in,
  output reg sda_oe_n,
  output reg [15:0] control_out,
  output reg [15:0] temp_used,
  output reg host_temp_sel,
  output reg [2:0] power_mode,
  input wire [15:0] die_temp_in,
  input wire [15:0] cell_mv_in,
  input wire [15:0] status_in,
  input wire [15:0] nom_cap_in,
  input wire [15:0] full_avail_in,
  input wire [15:0] charge_left_in,
  input wire [15:0] cap_full_in,
  input wire [15:0] mean_cur_in,
  input wire [15:0] idle_cur_in,
  input wire [15:0] peak_cur_in,
  input wire [15:0] mean_pwr_in,
  input wire [15:0] fill_in,
  input wire [15:0] wear_in,
  input wire wake_event,
  input wire load_idle
);
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_ACK = 3'd2;
  localparam ST_CMD = 3'd3;
  localparam ST_WDATA = 3'd4;
  localparam ST_RDATA = 3'd5;
  localparam ST_RACK = 3'd6;
  localparam ST_SKIP = 3'd7;

  wire scl_s;
  wire sda_s;
  reg scl_d;
  reg sda_d;
  reg [2:0] state;
  reg [2:0] after_ack;
  reg [3:0] bit_cnt;
  reg [7:0] shift;
  reg [7:0] cmd_ptr;
  reg is_read;
  reg ack_drive;
  reg hib_req;
  reg shdn_en;
  reg [15:0] host_temp;
  reg [7:0] rd_byte;
  reg [15:0] rd_word;
  reg writable;
  reg [31:0] init_cnt;
  reg [31:0] idle_cnt;
  wire [15:0] status_word;

  gscp_sync u_scl (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in(scl_in),
    .sync_out(scl_s)
  );

  gscp_sync u_sda (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in(sda_in),
    .sync_out(sda_s)
  );

  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_cond = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_cond = scl_s & scl_d & ~sda_d & sda_s;

  assign status_word = {shdn_en, 4'h0, power_mode, 1'b0, hib_req,
                        5'h00, host_temp_sel};

  // Control and temperature are the only writable codes
  always @* begin
    writable = ({cmd_ptr[7:1], 1'b0} == `GSCP_CMD_CONTROL) ||
               ({cmd_ptr[7:1], 1'b0} == `GSCP_CMD_CELL_TEMP);
  end

  // Each word answers at its pair of codes
  always @* begin
    case ({cmd_ptr[7:1], 1'b0})
      `GSCP_CMD_CONTROL: rd_word = status_word;
      `GSCP_CMD_CELL_TEMP: rd_word = temp_used;
      `GSCP_CMD_CELL_MV: rd_word = cell_mv_in;
      `GSCP_CMD_STATUS: rd_word = status_in;
      `GSCP_CMD_NOM_CAP: rd_word = nom_cap_in;
      `GSCP_CMD_FULL_AVAIL: rd_word = full_avail_in;
      `GSCP_CMD_CHARGE_LEFT: rd_word = charge_left_in;
      `GSCP_CMD_CAP_FULL: rd_word = cap_full_in;
      `GSCP_CMD_MEAN_CUR: rd_word = mean_cur_in;
      `GSCP_CMD_IDLE_CUR: rd_word = idle_cur_in;
      `GSCP_CMD_PEAK_CUR: rd_word = peak_cur_in;
      `GSCP_CMD_MEAN_PWR: rd_word = mean_pwr_in;
      `GSCP_CMD_FILL: rd_word = fill_in;
      `GSCP_CMD_DIE_TEMP: rd_word = die_temp_in;
      `GSCP_CMD_WEAR: rd_word = wear_in;
      default: rd_word = 16'h0000;
    endcase
    rd_byte = cmd_ptr[0] ? rd_word[15:8] : rd_word[7:0];
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // Serial engine; the low phase after a byte carries the ack
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      after_ack <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      cmd_ptr <= 8'h00;
      is_read <= 1'b0;
      ack_drive <= 1'b0;
      sda_oe_n <= 1'b1;
      control_out <= `GSCP_CONTROL_RST;
      host_temp <= `GSCP_TEMP_RST;
      host_temp_sel <= 1'b0;
      hib_req <= 1'b0;
      shdn_en <= 1'b0;
    end else if (start_cond) begin
      // Repeated start keeps the pointer so a read follows a command
      state <= ST_ADDR;
      bit_cnt <= 4'h0;
      sda_oe_n <= 1'b1;
    end else if (stop_cond) begin
      state <= ST_IDLE;
      sda_oe_n <= 1'b1;
    end else begin
      case (state)
        ST_IDLE: begin
          sda_oe_n <= 1'b1;
        end
        ST_ADDR, ST_CMD, ST_WDATA: begin
          if (scl_rise) begin
            shift <= {shift[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end
          if (scl_fall && bit_cnt == 4'h8) begin
            bit_cnt <= 4'h0;
            state <= ST_ACK;
            after_ack <= ST_SKIP;
            ack_drive <= 1'b0;
            if (state == ST_ADDR) begin
              if (shift[7:1] == `GSCP_BUS_ADDR) begin
                is_read <= shift[0];
                ack_drive <= 1'b1;
                if (shift[0] && cmd_ptr > `GSCP_CMD_TOP) begin
                  ack_drive <= 1'b0;
                end else if (shift[0]) begin
                  after_ack <= ST_RDATA;
                end else begin
                  after_ack <= ST_CMD;
                end
              end
            end else if (state == ST_CMD) begin
              cmd_ptr <= shift;
              ack_drive <= 1'b1;
              after_ack <= ST_WDATA;
            end else if (writable) begin
              ack_drive <= 1'b1;
              after_ack <= ST_WDATA;
              cmd_ptr <= cmd_ptr + 8'h01;
              case ({cmd_ptr[7:1], 1'b0})
                `GSCP_CMD_CONTROL: begin
                  if (cmd_ptr[0]) begin
                    control_out[15:8] <= shift;
                  end else begin
                    control_out[7:0] <= shift;
                  end
                end
                default: begin
                  // Host temperature overrides the die sensor
                  host_temp_sel <= 1'b1;
                  if (cmd_ptr[0]) begin
                    host_temp[15:8] <= shift;
                  end else begin
                    host_temp[7:0] <= shift;
                  end
                end
              endcase
            end
            // A high byte to control completes a subcommand
            if (state == ST_WDATA && writable && cmd_ptr[0] &&
                cmd_ptr[7:1] == 7'h00) begin
              case ({shift, control_out[7:0]})
                `GSCP_SUB_SET_HIB: hib_req <= 1'b1;
                `GSCP_SUB_CLR_HIB: hib_req <= 1'b0;
                `GSCP_SUB_SHDN_EN: shdn_en <= 1'b1;
                default: hib_req <= hib_req;
              endcase
            end
          end
        end
        ST_ACK: begin
          sda_oe_n <= ~ack_drive;
          if (scl_fall) begin
            sda_oe_n <= 1'b1;
            state <= after_ack;
            if (after_ack == ST_RDATA) begin
              shift <= rd_byte;
              sda_oe_n <= rd_byte[7];
              bit_cnt <= 4'h1;
            end
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (bit_cnt == 4'h8) begin
              sda_oe_n <= 1'b1;
              state <= ST_RACK;
            end else begin
              sda_oe_n <= shift[7 - bit_cnt[2:0]];
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            if (!sda_s) begin
              cmd_ptr <= cmd_ptr + 8'h01;
              state <= ST_ACK;
              ack_drive <= 1'b0;
              after_ack <= ST_RDATA;
            end else begin
              state <= ST_SKIP;
            end
          end
        end
        ST_SKIP: begin
          sda_oe_n <= 1'b1;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      temp_used <= `GSCP_TEMP_RST;
    end else begin
      temp_used <= host_temp_sel ? host_temp : die_temp_in;
    end
  end

  // Power modes; shutdown needs a prior enable subcommand
  // One pulse on the high byte, so a stale control word cannot
  // send the gauge straight back down after a wake
  reg shdn_cmd;
  wire bus_busy = (state != ST_IDLE);

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      shdn_cmd <= 1'b0;
    end else begin
      shdn_cmd <= shdn_en && (state == ST_WDATA) && scl_fall &&
                  (bit_cnt == 4'h8) && (cmd_ptr == 8'h01) &&
                  ({shift, control_out[7:0]} == `GSCP_SUB_SHDN);
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      power_mode <= `GSCP_MODE_INIT;
      init_cnt <= 32'h0000_0000;
      idle_cnt <= 32'h0000_0000;
    end else begin
      idle_cnt <= (bus_busy || !load_idle) ? 32'h0000_0000 :
                  ((idle_cnt == IDLE_CYC) ? idle_cnt :
                  idle_cnt + 32'h0000_0001);
      case (power_mode)
        `GSCP_MODE_INIT: begin
          init_cnt <= init_cnt + 32'h0000_0001;
          if (init_cnt == `GSCP_INIT_CYC - 1) begin
            power_mode <= `GSCP_MODE_NORMAL;
          end
        end
        `GSCP_MODE_NORMAL: begin
          if (shdn_cmd) begin
            power_mode <= `GSCP_MODE_SHUTDOWN;
          end else if (idle_cnt == IDLE_CYC) begin
            power_mode <= `GSCP_MODE_SLEEP;
          end
        end
        `GSCP_MODE_SLEEP: begin
          if (shdn_cmd) begin
            power_mode <= `GSCP_MODE_SHUTDOWN;
          end else if (!load_idle || bus_busy) begin
            power_mode <= `GSCP_MODE_NORMAL;
          end else if (hib_req) begin
            power_mode <= `GSCP_MODE_HIBERNATE;
          end
        end
        `GSCP_MODE_HIBERNATE: begin
          if (!load_idle || !hib_req) begin
            power_mode <= `GSCP_MODE_NORMAL;
          end
        end
        `GSCP_MODE_SHUTDOWN: begin
          if (wake_event) begin
            power_mode <= `GSCP_MODE_INIT;
            init_cnt <= 32'h0000_0000;
          end
        end
        default: power_mode <= `GSCP_MODE_INIT;
      endcase
    end
  end
endmodule // gscp_command_port

// ===== common/gscp_regs.vh
`ifndef GSCP_REGS_VH
`define GSCP_REGS_VH
// Bus address of the gauge, seven bits
`define GSCP_BUS_ADDR 7'h55
// Command codes, low byte at the even code
`define GSCP_CMD_CONTROL 8'h00
`define GSCP_CMD_CELL_TEMP 8'h02
`define GSCP_CMD_CELL_MV 8'h04
`define GSCP_CMD_STATUS 8'h06
`define GSCP_CMD_NOM_CAP 8'h08
`define GSCP_CMD_FULL_AVAIL 8'h0a
`define GSCP_CMD_CHARGE_LEFT 8'h0c
`define GSCP_CMD_CAP_FULL 8'h0e
`define GSCP_CMD_MEAN_CUR 8'h10
`define GSCP_CMD_IDLE_CUR 8'h12
`define GSCP_CMD_PEAK_CUR 8'h14
`define GSCP_CMD_MEAN_PWR 8'h18
`define GSCP_CMD_FILL 8'h1c
`define GSCP_CMD_DIE_TEMP 8'h1e
`define GSCP_CMD_WEAR 8'h20
`define GSCP_CMD_TOP 8'h6b
// Reset values
`define GSCP_CONTROL_RST 16'h0000
`define GSCP_TEMP_RST 16'h0000
// Control subcommands that steer the power modes
`define GSCP_SUB_SET_HIB 16'h0011
`define GSCP_SUB_CLR_HIB 16'h0012
`define GSCP_SUB_SHDN_EN 16'h001b
`define GSCP_SUB_SHDN 16'h001c
// Power mode codes
`define GSCP_MODE_INIT 3'h0
`define GSCP_MODE_NORMAL 3'h1
`define GSCP_MODE_SLEEP 3'h2
`define GSCP_MODE_HIBERNATE 3'h3
`define GSCP_MODE_SHUTDOWN 3'h4
// Field positions of the status word read back at the control code
`define GSCP_CS_HIB_BIT 6
`define GSCP_CS_SHDN_EN_BIT 15
`define GSCP_CS_HOST_TEMP_BIT 0
`define GSCP_CS_MODE_LSB 8
// Timing
`define GSCP_CLK_MHZ 250
`define GSCP_INIT_US 13
`define GSCP_INIT_CYC (`GSCP_INIT_US * `GSCP_CLK_MHZ)
`define GSCP_IDLE_MS 5
`define GSCP_IDLE_CYC (`GSCP_IDLE_MS * 1000 * `GSCP_CLK_MHZ)
`endif

// ===== src/gscp_sync.v
module gscp_sync (
  input wire ref_clk,
  input wire rst,
  input wire async_in,
  output reg sync_out
);
  reg stage1;

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stage1 <= 1'b1;
      sync_out <= 1'b1;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule // gscp_sync

// ===== testbench/gscp_command_port_props.sv
module gscp_command_port_chk (
  input wire ref_clk,
  input wire rst,
  input wire scl_in,
  input wire sda_oe_n,
  input wire [15:0] control_out,
  input wire [15:0] temp_used,
  input wire host_temp_sel,
  input wire [2:0] power_mode,
  input wire [15:0] die_temp_in,
  input wire wake_event,
  input wire load_idle
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [12:0] init_cnt;
  // Counts cycles spent in init since entry
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      init_cnt <= 13'h0000;
    end else if (power_mode == 3'h0) begin
      init_cnt <= init_cnt + 13'h0001;
    end else begin
      init_cnt <= 13'h0000;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  reset_vals_a: assert property (
    $fell(rst) |-> sda_oe_n && control_out == 16'h0000 && power_mode == 3'h0)
    else $error("state not cleared by reset");
  // Bus line may only move while the clock is low
  sda_change_a: assert property (
    $changed(sda_oe_n) |-> !scl_in)
    else $error("data line moved while clock high");
  mode_range_a: assert property (power_mode <= 3'h4)
    else $error("power mode code out of range");
  init_time_a: assert property (
    $fell(power_mode == 3'h0) |-> power_mode == 3'h1 &&
      init_cnt >= 13'h0cb0 && init_cnt <= 13'h0cb4)
    else $error("init phase length wrong");
  sleep_cause_a: assert property (
    $rose(power_mode == 3'h2) |-> $past(load_idle) && $past(power_mode) == 3'h1)
    else $error("sleep entered without cause");
  hib_entry_a: assert property (
    $rose(power_mode == 3'h3) |-> $past(power_mode) == 3'h2)
    else $error("hibernate entered not from sleep");
  shdn_exit_a: assert property (
    $fell(power_mode == 3'h4) |-> power_mode == 3'h0 &&
      ($past(wake_event) || $past(wake_event, 2) || $past(wake_event, 3)))
    else $error("shutdown left without wake");
  temp_sticky_a: assert property (!$fell(host_temp_sel))
    else $error("host temperature select dropped");
  temp_source_a: assert property (
    !host_temp_sel && $stable(die_temp_in) |=>
      host_temp_sel || temp_used == $past(die_temp_in))
    else $error("internal temperature not in use");
endmodule // gscp_command_port_chk

bind gscp_command_port gscp_command_port_chk i_chk (
  .ref_clk(ref_clk),
  .rst(rst),
  .scl_in(scl_in),
  .sda_oe_n(sda_oe_n),
  .control_out(control_out),
  .temp_used(temp_used),
  .host_temp_sel(host_temp_sel),
  .power_mode(power_mode),
  .die_temp_in(die_temp_in),
  .wake_event(wake_event),
  .load_idle(load_idle)
);

// ===== testbench/gscp_host_model.sv
module gscp_host_model #(
  parameter int BUF_CYC = 300
) (
  input wire ref_clk,
  input wire sda_in,
  output logic scl_out,
  output logic sda_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Serves as start and repeated start
  task automatic start();
    sda_out <= 1'b1;
    tick(4);
    scl_out <= 1'b1;
    tick(4);
    sda_out <= 1'b0;
    tick(4);
    scl_out <= 1'b0;
    tick(4);
  endtask
  // Low phase stretched so the synced ack lands before the rise
  task automatic bit_x(input logic b, output logic r);
    sda_out <= b;
    tick(3);
    scl_out <= 1'b1;
    tick(2);
    r = sda_in;
    scl_out <= 1'b0;
    tick(3);
  endtask
  task automatic xfer(input logic [7:0] d, input logic m,
                      output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
      q[i] = r;
    end
    bit_x(m, r);
    ack = !r;
  endtask
  task automatic stop();
    sda_out <= 1'b0;
    tick(4);
    scl_out <= 1'b1;
    tick(4);
    sda_out <= 1'b1;
    // Free time scaled down along with the compressed bus clock
    tick(BUF_CYC);
  endtask
endmodule // gscp_host_model

// ===== testbench/gscp_command_port_tb.sv
module gscp_command_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic wake_event = 1'b0;
  logic load_idle = 1'b0;
  wire scl, sda_h, sda_oe_n, host_temp_sel;
  wire [15:0] control_out, temp_used;
  wire [2:0] power_mode;
  // Pull-up: released line reads high
  wire sda = sda_h & sda_oe_n;
  int fail_count = 0;
  int check_count = 0;
  function automatic logic [15:0] val(input logic [7:0] c);
    return {c ^ 8'h3c, c + 8'h51};
  endfunction
  gscp_command_port #(.IDLE_CYC(200)) i_dut (
    .ref_clk(ref_clk), .rst(rst), .scl_in(scl), .sda_in(sda),
    .sda_oe_n(sda_oe_n), .control_out(control_out), .temp_used(temp_used),
    .host_temp_sel(host_temp_sel), .power_mode(power_mode),
    .die_temp_in(val(8'h1e)), .cell_mv_in(val(8'h04)),
    .status_in(val(8'h06)), .nom_cap_in(val(8'h08)),
    .full_avail_in(val(8'h0a)), .charge_left_in(val(8'h0c)),
    .cap_full_in(val(8'h0e)), .mean_cur_in(val(8'h10)),
    .idle_cur_in(val(8'h12)), .peak_cur_in(val(8'h14)),
    .mean_pwr_in(val(8'h18)), .fill_in(val(8'h1c)), .wear_in(val(8'h20)),
    .wake_event(wake_event), .load_idle(load_idle)
  );
  gscp_host_model #(.BUF_CYC(300)) i_host (
    .ref_clk(ref_clk), .sda_in(sda), .scl_out(scl), .sda_out(sda_h)
  );
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr8(input logic [7:0] c, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic a0, a1, a2;
    i_host.start();
    i_host.xfer(8'haa, 1'b1, q, a0);
    i_host.xfer(c, 1'b1, q, a1);
    i_host.xfer(d, 1'b1, q, a2);
    i_host.stop();
    ok = a0 & a1 & a2;
  endtask
  // Fast clock: one data byte per packet
  task automatic wr16(input logic [7:0] c, input logic [15:0] d);
    logic ok;
    wr8(c, d[7:0], ok);
    chk(16'(ok), 16'h0001);
    wr8(c + 8'h01, d[15:8], ok);
    chk(16'(ok), 16'h0001);
  endtask
  task automatic rd16(input logic [7:0] c, output logic [15:0] v,
                      output logic ok);
    logic a0, a1, a2, x;
    i_host.start();
    i_host.xfer(8'haa, 1'b1, v[7:0], a0);
    i_host.xfer(c, 1'b1, v[7:0], a1);
    i_host.start();
    i_host.xfer(8'hab, 1'b1, v[7:0], a2);
    i_host.xfer(8'hff, 1'b0, v[7:0], x);
    i_host.xfer(8'hff, 1'b1, v[15:8], x);
    i_host.stop();
    ok = a0 & a1 & a2;
  endtask
  task automatic wait_mode(input logic [2:0] m, input int n);
    int i = 0;
    while (power_mode !== m && i < n) begin
      @(posedge ref_clk);
      i++;
    end
    chk(16'(power_mode), 16'(m));
  endtask
  task automatic t_reset();
    chk(16'(sda_oe_n), 16'h0001);
    chk(control_out, 16'h0000);
    chk(16'(power_mode), 16'h0000);
    chk(16'(host_temp_sel), 16'h0000);
    wait_mode(3'h1, 3400);
  endtask
  task automatic t_reads();
    logic [7:0] c [16] = '{8'h02, 8'h04, 8'h06, 8'h08, 8'h0a, 8'h0c, 8'h0e,
      8'h10, 8'h12, 8'h14, 8'h18, 8'h1c, 8'h1e, 8'h20, 8'h16, 8'h6a};
    logic [15:0] v, e;
    logic ok;
    foreach (c[i]) begin
      e = (c[i] == 8'h16 || c[i] == 8'h6a) ? 16'h0000 :
          val(c[i] == 8'h02 ? 8'h1e : c[i]);
      rd16(c[i], v, ok);
      chk(v, e);
      chk(16'(ok), 16'h0001);
    end
    // Odd start: pointer walks across a word boundary
    rd16(8'h05, v, ok);
    e = val(8'h06) << 8;
    e[7:0] = 8'(val(8'h04) >> 8);
    chk(v, e);
  endtask
  task automatic t_refuse();
    logic [15:0] v;
    logic [7:0] q;
    logic ok;
    i_host.start();
    i_host.xfer(8'ha8, 1'b1, q, ok);
    i_host.stop();
    chk(16'(ok), 16'h0000);
    wr8(8'h04, 8'h55, ok);
    chk(16'(ok), 16'h0000);
    rd16(8'h6c, v, ok);
    chk(16'(ok), 16'h0000);
  endtask
  task automatic t_temp();
    logic [15:0] v;
    logic ok;
    wr16(8'h02, 16'h0bb8);
    chk(16'(host_temp_sel), 16'h0001);
    chk(temp_used, 16'h0bb8);
    rd16(8'h02, v, ok);
    chk(v, 16'h0bb8);
  endtask
  task automatic t_modes();
    logic [15:0] v;
    logic ok;
    wr16(8'h00, 16'h0011);
    chk(control_out, 16'h0011);
    rd16(8'h00, v, ok);
    chk({v[10:8], v[6]}, 16'h0003);
    load_idle <= 1'b1;
    wait_mode(3'h2, 400);
    wait_mode(3'h3, 400);
    // Load returns: hibernate falls back to normal before shutdown
    load_idle <= 1'b0;
    wait_mode(3'h1, 20);
    wr16(8'h00, 16'h001b);
    wr16(8'h00, 16'h001c);
    wait_mode(3'h4, 400);
    wake_event <= 1'b1;
    @(posedge ref_clk);
    wake_event <= 1'b0;
    wait_mode(3'h0, 20);
    wait_mode(3'h1, 3400);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge ref_clk);
    fail_count++;
    print_verdict();
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    t_reset();
    t_reads();
    t_refuse();
    t_temp();
    t_modes();
    print_verdict();
  end
endmodule // gscp_command_port_tb
